// ---- bench/crosspoint_smbus_config_regs_tb.sv ----
// self-checking bench of the crosspoint configuration register bank
`default_nettype none
module crosspoint_smbus_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [7:0] idx; logic [7:0] wr; logic [7:0] rd; } xpsm_row_t;
    localparam logic [3:0] STRAP = 4'hA;
    localparam logic [6:0] ADDR  = {3'h5, STRAP};
    logic       i_clk, i_rst_n, mode, pwr, sda_pull, scl, sda_o, sda_oe, mon;
    logic [3:0] strap, txp, rxp, oen, ien;
    logic [7:0] rsel, route, txb, rxb;
    logic [2:0] nk;
    wire logic  sda_w;
    int         err_total = 0;
    int         comparisons = 0;
    xpsm_row_t  rows [6] = '{'{8'h00, 8'hE4, 8'hE4}, '{8'h01, 8'h1B, 8'h1B},
        '{8'h02, 8'hE4, 8'hE4}, '{8'h03, 8'h3F, 8'h3F}, '{8'h04, 8'h55, 8'h00},
        '{8'h07, 8'hFF, 8'h00}};
    assign sda_w = ~(sda_pull | (sda_oe & ~sda_o));
    xpsm_host xpsm_host_inst (.o_scl(scl), .o_sda_pull(sda_pull), .i_sda(sda_w));
    xpsm_regbank #(.P_IDLE_CYC(50)) xpsm_regbank_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_w), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_smbus_mode(mode), .i_power_down_pin(pwr),
        .i_slave_id_strap(strap), .i_route_select_pin(rsel), .i_tx_boost_pin(txp),
        .i_rx_boost_pin(rxp), .o_route_sel(route), .o_tx_boost(txb), .o_rx_boost(rxb),
        .o_output_en(oen), .o_input_en(ien), .o_open_input_monitor_en(mon));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle;
        repeat (5) @(posedge i_clk);
        #1;
    endtask
    task automatic do_reset;
        i_rst_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        settle;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xpsm_host_inst.write_reg(ADDR, idx, d, nk);
        chk("write acks", 8'h00, {5'h0, nk});
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        xpsm_host_inst.read_reg(ADDR, idx, d, nk);
        chk("read acks", 8'h00, {5'h0, nk});
        chk(what, exp, d);
    endtask
    initial begin
        repeat (90000) @(posedge i_clk);
        err_total++;
        $display("ERROR run length expected done seen timeout");
        wrap_up;
    end
    initial begin
        {i_rst_n, mode, pwr, strap, rsel, txp, rxp} = {1'b0, 1'b1, 1'b1, STRAP, 8'h1B, 8'h53};
        do_reset;
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].idx, rows[i].wr);
            rdchk("readback", rows[i].idx, rows[i].rd);
        end
        settle;
        chk("route", 8'hE4, route);
        chk("tx boost", 8'h1B, txb);
        chk("rx boost", 8'hE4, rxb);
        chk("out en", 8'h0F, {4'h0, oen});
        chk("in en", 8'h0F, {4'h0, ien});
        do_reset;
        rdchk("route rst", 8'h00, 8'h00);
        rdchk("tx rst", 8'h01, 8'h00);
        rdchk("rx rst", 8'h02, 8'h00);
        rdchk("ctrl rst", 8'h03, 8'h0F);
        settle;
        chk("tx pins", 8'h22, txb);
        chk("rx pins", 8'h05, rxb);
        chk("in en idle", 8'h01, {4'h0, ien});
        chk("monitor off", 8'h00, {7'h0, mon});
        pwr = 1'b0;
        settle;
        chk("out en pdn", 8'h00, {4'h0, oen});
        chk("in en pdn", 8'h00, {4'h0, ien});
        wr(8'h03, 8'h4F);
        settle;
        chk("in en mon", 8'h0F, {4'h0, ien});
        chk("monitor on", 8'h01, {7'h0, mon});
        chk("out en mon", 8'h00, {4'h0, oen});
        wr(8'h03, 8'h8E);
        settle;
        chk("out en soft", 8'h0E, {4'h0, oen});
        chk("in en soft", 8'h01, {4'h0, ien});
        xpsm_host_inst.write_reg({3'h5, STRAP ^ 4'h1}, 8'h00, 8'hFF, nk);
        chk("strap miss", 8'h07, {5'h0, nk});
        xpsm_host_inst.write_reg({3'h4, STRAP}, 8'h00, 8'hFF, nk);
        chk("upper miss", 8'h07, {5'h0, nk});
        rdchk("route kept", 8'h00, 8'h00);
        xpsm_host_inst.start_cond;
        xpsm_host_inst.send_byte({ADDR, 1'b0}, nk[0]);
        chk("idle addr", 8'h00, {7'h0, nk[0]});
        xpsm_host_inst.park(100);
        xpsm_host_inst.send_byte(8'h00, nk[0]);
        xpsm_host_inst.stop_cond;
        chk("after idle", 8'h01, {7'h0, nk[0]});
        mode = 1'b0;
        settle;
        chk("pin route", 8'h1B, route);
        xpsm_host_inst.write_reg(ADDR, 8'h00, 8'hFF, nk);
        chk("pin mode acks", 8'h07, {5'h0, nk});
        wrap_up;
    end
endmodule
`default_nettype wire

// ---- bench/xpsm_host.sv ----
// two-wire bus host model driving clock and data toward the register bank
`default_nettype none
module xpsm_host (
    output var  logic o_scl,
    output var  logic o_sda_pull,
    input  wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 40;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // start or repeated start: data falls while clock high
    task automatic start_cond;
        o_sda_pull = 1'b0;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda_pull = 1'b1;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    // stop: data rises while clock high, then clock stands high
    task automatic stop_cond;
        o_sda_pull = 1'b1;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda_pull = 1'b0;
        #Q;
    endtask
    // data set in clock low half, sampled in clock high half
    task automatic put_bit(input logic b, output logic seen);
        o_sda_pull = ~b;
        #Q;
        o_scl = 1'b1;
        #Q;
        seen = i_sda;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    // both lines high for a while without stop, then clock low again
    task automatic park(input int cyc);
        o_sda_pull = 1'b0;
        #Q;
        o_scl = 1'b1;
        #(cyc * 8);
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, nack);
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(last, s);
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [7:0] idx,
                             input logic [7:0] d, output logic [2:0] nk);
        start_cond;
        send_byte({a, 1'b0}, nk[2]);
        send_byte(idx, nk[1]);
        send_byte(d, nk[0]);
        stop_cond;
    endtask
    task automatic read_reg(input logic [6:0] a, input logic [7:0] idx,
                            output logic [7:0] d, output logic [2:0] nk);
        start_cond;
        send_byte({a, 1'b0}, nk[2]);
        send_byte(idx, nk[1]);
        start_cond;
        send_byte({a, 1'b1}, nk[0]);
        recv_byte(1'b1, d);
        stop_cond;
    endtask
endmodule
`default_nettype wire

// ---- rtl/xpsm_pkg.sv ----
// constants and types of the crosspoint configuration register bank
`default_nettype none
package xpsm_pkg;
    // register indices
    localparam logic [7:0] REG_ROUTE = 8'h00;
    localparam logic [7:0] REG_TXB   = 8'h01;
    localparam logic [7:0] REG_RXB   = 8'h02;
    localparam logic [7:0] REG_CTRL  = 8'h03;
    localparam logic [7:0] REG_LAST  = 8'h03;
    // reset values
    localparam logic [7:0] RST_ROUTE = 8'h00;
    localparam logic [7:0] RST_TXB   = 8'h00;
    localparam logic [7:0] RST_RXB   = 8'h00;
    localparam logic [7:0] RST_CTRL  = 8'h0F;
    // control fields
    localparam int CTRL_RXO  = 4;
    localparam int CTRL_TXO  = 5;
    localparam int CTRL_MON  = 6;
    localparam int CTRL_SOFT = 7;
    // fixed upper slave address bits, binary 101
    localparam logic [2:0] ADDR_HI = 3'h5;
    localparam logic       RW_READ = 1'h1;
    // boost levels
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_MED = 2'h2;
    localparam logic [1:0] LVL_HI  = 2'h3;
    // bit counter marks
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    // bus idle time
    localparam int CLK_NS      = 8;
    localparam int BUS_IDLE_NS = 50000;
    localparam int IDLE_CYC    = (BUS_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_W      = 25;
    // clock and data synchronise from their idle high level
    localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, (SYNC_W - 2)'(0)};
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_INDEX = 3'h3,
        ST_WDATA = 3'h2,
        ST_RDATA = 3'h6,
        ST_SKIP  = 3'h7
    } xpsm_state_t;
endpackage
`default_nettype wire

// ---- rtl/xpsm_regbank.sv ----
// crosspoint switch configuration register bank behind a two-wire slave
`default_nettype none
module xpsm_regbank #(
    parameter int P_IDLE_CYC = xpsm_pkg::IDLE_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda_o,
    output var  logic       o_sda_oe,
    input  wire logic       i_smbus_mode,
    input  wire logic       i_power_down_pin,
    input  wire logic [3:0] i_slave_id_strap,
    input  wire logic [7:0] i_route_select_pin,
    input  wire logic [3:0] i_tx_boost_pin,
    input  wire logic [3:0] i_rx_boost_pin,
    output var  logic [7:0] o_route_sel,
    output var  logic [7:0] o_tx_boost,
    output var  logic [7:0] o_rx_boost,
    output var  logic [3:0] o_output_en,
    output var  logic [3:0] o_input_en,
    output var  logic       o_open_input_monitor_en
);
    localparam int CW = $clog2(P_IDLE_CYC + 1);

    // link domain: capture each bit at the rising clock edge
    logic bit_tog_q;
    logic bit_val_q;

    always_ff @(posedge i_scl or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_tog_q <= 1'b0;
            bit_val_q <= 1'b0;
        end else begin
            bit_tog_q <= ~bit_tog_q;
            bit_val_q <= i_sda;
        end
    end

    // pin and toggle synchronisers
    logic [xpsm_pkg::SYNC_W-1:0] sync1_q;
    logic [xpsm_pkg::SYNC_W-1:0] sync2_q;
    logic       scl_s;
    logic       sda_s;
    logic       mode_s;
    logic       pd_s;
    logic [3:0] strap_s;
    logic [7:0] route_pin_s;
    logic [3:0] tx_pin_s;
    logic [3:0] rx_pin_s;
    logic       tog_s;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= xpsm_pkg::SYNC_RST;
            sync2_q <= xpsm_pkg::SYNC_RST;
        end else begin
            sync1_q <= {i_scl, i_sda, i_smbus_mode, i_power_down_pin,
                        i_slave_id_strap, i_route_select_pin,
                        i_tx_boost_pin, i_rx_boost_pin, bit_tog_q};
            sync2_q <= sync1_q;
        end
    end

    assign {scl_s, sda_s, mode_s, pd_s, strap_s, route_pin_s,
            tx_pin_s, rx_pin_s, tog_s} = sync2_q;

    // line edge history
    logic scl_prev_q;
    logic sda_prev_q;
    logic tog_prev_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            tog_prev_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            tog_prev_q <= tog_s;
        end
    end

    logic start_det;
    logic stop_det;
    logic bit_evt;
    logic scl_fall;
    logic idle_hit;
    logic [CW-1:0] idle_cnt_q;

    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign bit_evt   = tog_s ^ tog_prev_q;
    assign scl_fall  = scl_prev_q & ~scl_s;
    assign idle_hit  = scl_s & sda_s & (idle_cnt_q == CW'(P_IDLE_CYC - 1));

    // both lines high timer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_cnt_q <= '0;
        end else if (!(scl_s & sda_s) || idle_hit) begin
            idle_cnt_q <= '0;
        end else begin
            idle_cnt_q <= idle_cnt_q + CW'(1);
        end
    end

    // protocol engine
    xpsm_pkg::xpsm_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] index_q;
    logic [7:0] rd_q;
    logic       ack_q;
    logic [7:0] regs_q [4];
    logic [7:0] byte_now;
    logic [7:0] rd_val;
    logic [6:0] own_addr;
    logic       abort;
    logic       byte_done;

    assign byte_now  = {shift_q[6:0], bit_val_q};
    assign own_addr  = {xpsm_pkg::ADDR_HI, strap_s};
    assign abort     = !mode_s || stop_det || idle_hit;
    assign byte_done = !abort && !start_det && bit_evt &&
                       (st_q != xpsm_pkg::ST_IDLE) && (cnt_q == xpsm_pkg::BIT_LAST);
    assign rd_val    = (index_q <= xpsm_pkg::REG_LAST) ? regs_q[index_q[1:0]] : 8'h00;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q    <= xpsm_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 8'h00;
            rd_q    <= 8'h00;
            ack_q   <= 1'b0;
        end else if (abort) begin
            st_q  <= xpsm_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end else if (start_det) begin
            st_q  <= xpsm_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end else if (bit_evt && st_q != xpsm_pkg::ST_IDLE) begin
            if (cnt_q == xpsm_pkg::BIT_ACK) begin
                cnt_q <= 4'h0;
                ack_q <= 1'b0;
                if (st_q == xpsm_pkg::ST_RDATA) begin
                    rd_q <= rd_val;
                    st_q <= bit_val_q ? xpsm_pkg::ST_SKIP : xpsm_pkg::ST_RDATA;
                end
            end else begin
                cnt_q   <= cnt_q + 4'h1;
                shift_q <= byte_now;
                if (cnt_q == xpsm_pkg::BIT_LAST) begin
                    case (st_q)
                        xpsm_pkg::ST_ADDR: begin
                            if (byte_now[7:1] == own_addr) begin
                                ack_q <= 1'b1;
                                if (byte_now[0] == xpsm_pkg::RW_READ) begin
                                    st_q <= xpsm_pkg::ST_RDATA;
                                    rd_q <= rd_val;
                                end else begin
                                    st_q <= xpsm_pkg::ST_INDEX;
                                end
                            end else begin
                                st_q <= xpsm_pkg::ST_SKIP;
                            end
                        end
                        xpsm_pkg::ST_INDEX: begin
                            index_q <= byte_now;
                            ack_q   <= 1'b1;
                            st_q    <= xpsm_pkg::ST_WDATA;
                        end
                        xpsm_pkg::ST_WDATA: begin
                            ack_q <= 1'b1;
                        end
                        default: begin
                            ack_q <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // data line drive, set at clock falls, released at once on start, stop, bus idle or pin mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda_o  <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            o_sda_o <= 1'b0;
            if (abort || start_det) begin
                o_sda_oe <= 1'b0;
            end else if (scl_fall) begin
                if (cnt_q == xpsm_pkg::BIT_ACK) begin
                    o_sda_oe <= ack_q;
                end else begin
                    o_sda_oe <= (st_q == xpsm_pkg::ST_RDATA) &&
                                !rd_q[3'(xpsm_pkg::BIT_LAST - cnt_q)];
                end
            end
        end
    end

    // register file
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            regs_q[0] <= xpsm_pkg::RST_ROUTE;
            regs_q[1] <= xpsm_pkg::RST_TXB;
            regs_q[2] <= xpsm_pkg::RST_RXB;
            regs_q[3] <= xpsm_pkg::RST_CTRL;
        end else if (byte_done && st_q == xpsm_pkg::ST_WDATA &&
                     index_q <= xpsm_pkg::REG_LAST) begin
            regs_q[index_q[1:0]] <= byte_now;
        end
    end

    // per channel outputs
    logic [7:0] ctrl;
    logic [7:0] route_d;
    logic       power_up;

    assign ctrl     = regs_q[3];
    assign route_d  = mode_s ? regs_q[0] : route_pin_s;
    assign power_up = pd_s | ctrl[xpsm_pkg::CTRL_SOFT];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_route_sel             <= 8'h00;
            o_open_input_monitor_en <= 1'b0;
        end else begin
            o_route_sel             <= route_d;
            o_open_input_monitor_en <= ctrl[xpsm_pkg::CTRL_MON];
        end
    end

    for (genvar n = 0; n < 4; n++) begin : g_ch
        logic used;
        assign used = (route_d[1:0] == 2'(n)) || (route_d[3:2] == 2'(n)) ||
                      (route_d[5:4] == 2'(n)) || (route_d[7:6] == 2'(n));

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_tx_boost[2*n+:2] <= xpsm_pkg::LVL_OFF;
                o_rx_boost[2*n+:2] <= xpsm_pkg::LVL_OFF;
                o_output_en[n]     <= 1'b0;
                o_input_en[n]      <= 1'b0;
            end else begin
                if (mode_s && ctrl[xpsm_pkg::CTRL_TXO]) begin
                    o_tx_boost[2*n+:2] <= regs_q[1][2*n+:2];
                end else begin
                    o_tx_boost[2*n+:2] <= tx_pin_s[n] ? xpsm_pkg::LVL_MED
                                                      : xpsm_pkg::LVL_OFF;
                end
                if (mode_s && ctrl[xpsm_pkg::CTRL_RXO]) begin
                    o_rx_boost[2*n+:2] <= regs_q[2][2*n+:2];
                end else begin
                    o_rx_boost[2*n+:2] <= rx_pin_s[n] ? xpsm_pkg::LVL_LOW
                                                      : xpsm_pkg::LVL_OFF;
                end
                o_output_en[n] <= power_up & ctrl[n];
                o_input_en[n]  <= (power_up & used) |
                                  ctrl[xpsm_pkg::CTRL_MON];
            end
        end

        a_tx_pin_lvl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            !(mode_s && ctrl[xpsm_pkg::CTRL_TXO]) |=> o_tx_boost[2*n+:2] ==
            ($past(tx_pin_s[n]) ? xpsm_pkg::LVL_MED : xpsm_pkg::LVL_OFF))
            else $error("tx boost not taken from pin");
        a_rx_reg_lvl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            (mode_s && ctrl[xpsm_pkg::CTRL_RXO]) |=>
            o_rx_boost[2*n+:2] == $past(regs_q[2][2*n+:2]))
            else $error("rx boost not taken from register");
        a_out_power: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            ##1 o_output_en[n] == ($past(pd_s | ctrl[xpsm_pkg::CTRL_SOFT]) &&
            $past(ctrl[n])))
            else $error("output power state wrong");
        a_input_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            ctrl[xpsm_pkg::CTRL_MON] |=> o_input_en[n])
            else $error("input disabled while monitor enabled");
    end

    a_route_reg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        mode_s |=> o_route_sel == $past(regs_q[0]))
        else $error("routing not from register");
    a_route_pins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !mode_s |=> o_route_sel == $past(route_pin_s))
        else $error("routing not from select pins");
    a_addr_match: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (byte_done && st_q == xpsm_pkg::ST_ADDR && byte_now[7:1] == own_addr)
        |=> ack_q && st_q inside {xpsm_pkg::ST_INDEX, xpsm_pkg::ST_RDATA})
        else $error("own address not accepted");
    a_addr_foreign: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (byte_done && st_q == xpsm_pkg::ST_ADDR && byte_now[7:1] != own_addr)
        |=> !ack_q && st_q == xpsm_pkg::ST_SKIP)
        else $error("foreign address accepted");
    a_write_txb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (byte_done && st_q == xpsm_pkg::ST_WDATA && index_q == xpsm_pkg::REG_TXB)
        |=> regs_q[1] == $past(byte_now))
        else $error("tx boost register write lost");
    a_ack_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (scl_fall && !abort && !start_det && cnt_q == xpsm_pkg::BIT_ACK && ack_q)
        |=> o_sda_oe)
        else $error("acknowledge not driven");
    a_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        stop_det |=> st_q == xpsm_pkg::ST_IDLE && !o_sda_oe)
        else $error("stop did not end transfer");
    a_idle_time: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        idle_hit |=> st_q == xpsm_pkg::ST_IDLE)
        else $error("bus idle not detected");
endmodule
`default_nettype wire
